// file: inc/tsr_pkg.sv
/*
 * Package of the serial register access front end: pointer codes,
 * register reset values, slave address and time-out figures.
 * Assumes a 25 MHz system clock driving all logic.
 */
package tsr_pkg;
    // ****************************************
    // Clock and time-out
    // ****************************************
    localparam int CLK_HZ = 25000000;
    localparam int TIMEOUT_MIN_MS = 75;
    localparam int TIMEOUT_MAX_MS = 325;
    // Least time rounds up to whole cycles
    localparam longint TIMEOUT_CYC =
        (longint'(TIMEOUT_MIN_MS) * CLK_HZ + 999) / 1000;

    // ****************************************
    // Addressing and pointer
    // ****************************************
    localparam logic [3:0] ADDR_FIXED = 4'h9;
    localparam logic [1:0] PTR_TEMP = 2'h0;
    localparam logic [1:0] PTR_CONF = 2'h1;
    localparam logic [1:0] PTR_LOWER = 2'h2;
    localparam logic [1:0] PTR_UPPER = 2'h3;
    localparam logic [1:0] PTR_RESET = 2'h0;

    // ****************************************
    // Register reset values
    // ****************************************
    localparam logic [7:0] CONF_RESET = 8'h00;
    localparam logic [15:0] UPPER_RESET = 16'h5000;
    localparam logic [15:0] LOWER_RESET = 16'h4b00;
endpackage

// file: verif/tsr_master.sv
/* Two-wire bus master model: start, stop and nine-bit transfers.
   Assumes the bench resolves the open-drain data line with a pull-up. */
`timescale 1ns/1ns
module tsr_master (
    input wire logic clock_i,
    input wire logic sda_line_i,
    output logic scl_o,
    output logic sda_o
);
    // Clocks per half bit; raised to act as a slow master
    int half = 4;
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic tick();
        repeat (half) @(negedge clock_i);
    endtask
    task automatic start();
        sda_o = 1'b1;
        tick();
        scl_o = 1'b1;
        tick();
        sda_o = 1'b0;
        tick();
        scl_o = 1'b0;
    endtask
    task automatic stop();
        sda_o = 1'b0;
        tick();
        scl_o = 1'b1;
        tick();
        sda_o = 1'b1;
        tick();
    endtask
    // Eight data bits then the receiver's bit, no gaps
    task automatic xfer(input logic [7:0] tx, input logic ack_in,
                        output logic [7:0] rx, output logic ack_out);
        logic [8:0] sh;
        sh = {tx, ack_in};
        for (int i = 8; i >= 0; i--) begin
            sda_o = sh[i];
            tick();
            scl_o = 1'b1;
            tick();
            sh[i] = sda_line_i;
            scl_o = 1'b0;
        end
        sda_o = 1'b1;
        rx = sh[8:1];
        ack_out = sh[0];
    endtask
endmodule

// file: verif/tsr_slave_props.sv
/* Checker of the serial register front end, bound to its ports.
   Assumes one clock domain and a synchronous active-low reset. */
`timescale 1ns/1ns
module tsr_slave_props (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic [2:0] address_select_pins_i,
    input wire logic [15:0] temp_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic [1:0] pointer_word_address_o,
    input wire logic [7:0] conf_o,
    input wire logic [15:0] upper_trip_limit_o,
    input wire logic [15:0] lower_trip_limit_o,
    input wire logic timeout_o
);
    // ****
    // Properties
    // ****
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!nrst_i);
    reset_values_a: assert property (disable iff (1'b0)
        !nrst_i |=> pointer_word_address_o == 2'h0 && conf_o == 8'h00
        && upper_trip_limit_o == 16'h5000
        && lower_trip_limit_o == 16'h4b00 && !sda_oe_o)
        else $error("reset values wrong");
    timeout_release_a: assert property (timeout_o |=> !sda_oe_o)
        else $error("data line held after time-out");
    timeout_pulse_a: assert property (timeout_o |=> !timeout_o)
        else $error("time-out pulse too long");
    // The time-out may free the line at any clock level
    oe_scl_low_a: assert property ($changed(sda_oe_o)
        && !timeout_o |-> !scl_i)
        else $error("data changed while clock high");
    ptr_scl_low_a: assert property (
        $changed(pointer_word_address_o) |-> !scl_i)
        else $error("pointer changed while clock high");
    conf_sel_a: assert property ($changed(conf_o) |->
        pointer_word_address_o == tsr_pkg::PTR_CONF)
        else $error("config written through wrong pointer");
    upper_sel_a: assert property ($changed(upper_trip_limit_o) |->
        pointer_word_address_o == tsr_pkg::PTR_UPPER)
        else $error("upper limit written through wrong pointer");
    lower_sel_a: assert property ($changed(lower_trip_limit_o) |->
        pointer_word_address_o == tsr_pkg::PTR_LOWER)
        else $error("lower limit written through wrong pointer");
    drive_low_a: assert property (sda_o == 1'b0)
        else $error("data pad driven high");
endmodule
bind tsr_slave tsr_slave_props u_props (.clock_i(clock_i),
    .nrst_i(nrst_i), .scl_i(scl_i), .sda_i(sda_i),
    .address_select_pins_i(address_select_pins_i), .temp_i(temp_i),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .pointer_word_address_o(pointer_word_address_o), .conf_o(conf_o),
    .upper_trip_limit_o(upper_trip_limit_o),
    .lower_trip_limit_o(lower_trip_limit_o), .timeout_o(timeout_o));

// file: verif/tsr_slave_tb.sv
/* Self-checking bench of the serial register front end.
   Assumes the master model and the bound checker are compiled first. */
`timescale 1ns/1ns
module tsr_slave_tb;
    logic clock_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [2:0] pins = 3'h5;
    logic [15:0] temp = 16'h1a80;
    logic scl, msda, sda_o, sda_oe, tmo;
    logic [1:0] ptr;
    logic [7:0] conf;
    logic [15:0] up, lo, w;
    // Short time-out so that the release can be seen in a short run
    localparam longint TO_CYC = 400;
    int fails = 0;
    int checked = 0;
    int cycles = 0;
    wire sda = msda & ~(sda_oe & ~sda_o);
    tsr_slave #(.TIMEOUT_CYC(TO_CYC)) DUT (.clock_i(clock_i),
        .nrst_i(nrst_i), .scl_i(scl),
        .sda_i(sda), .address_select_pins_i(pins), .temp_i(temp),
        .sda_o(sda_o), .sda_oe_o(sda_oe), .pointer_word_address_o(ptr),
        .conf_o(conf), .upper_trip_limit_o(up),
        .lower_trip_limit_o(lo), .timeout_o(tmo));
    tsr_master M (.clock_i(clock_i), .sda_line_i(sda), .scl_o(scl),
        .sda_o(msda));
    always #20 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 30000) begin
            fails++;
            close_out();
        end
    end
    // ****
    // Shared tasks
    // ****
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                         input string msg);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    task automatic send(input logic [7:0] b);
        logic [7:0] rx;
        logic a;
        M.xfer(b, 1'b1, rx, a);
        check({15'h0000, a}, 16'h0000, "no acknowledge");
    endtask
    task automatic rd(input logic load, input logic [1:0] p, input int n);
        logic [7:0] b;
        logic a;
        w = 16'h0000;
        M.start();
        if (load) begin
            send({tsr_pkg::ADDR_FIXED, pins, 1'b0});
            send({6'h00, p});
            M.start();
        end
        send({tsr_pkg::ADDR_FIXED, pins, 1'b1});
        for (int i = 0; i < n; i++) begin
            M.xfer(8'hff, i == n - 1, b, a);
            w = {w[7:0], b};
        end
        M.stop();
    endtask
    task automatic wr(input logic [1:0] p, input int n,
                      input logic [15:0] d);
        M.start();
        send({tsr_pkg::ADDR_FIXED, pins, 1'b0});
        send({6'h00, p});
        for (int i = n - 1; i >= 0; i--)
            send(d[8*i +: 8]);
        M.stop();
    endtask
    // ****
    // Scenarios
    // ****
    task automatic t_reset();
        check({14'h0000, ptr}, 16'h0000, "pointer");
        check({8'h00, conf}, 16'h0000, "config");
        check(up, 16'h5000, "upper limit");
        check(lo, 16'h4b00, "lower limit");
        $display("reset test done");
    endtask
    task automatic t_default();
        M.half = 12;
        rd(1'b0, 2'h0, 2);
        check(w, temp, "default read");
        M.half = 4;
        $display("default read test done");
    endtask
    task automatic t_writes();
        wr(tsr_pkg::PTR_UPPER, 2, 16'hc680);
        wr(tsr_pkg::PTR_LOWER, 2, 16'h2d00);
        wr(tsr_pkg::PTR_CONF, 1, 16'h001e);
        check(up, 16'hc680, "upper write");
        check(lo, 16'h2d00, "lower write");
        check({8'h00, conf}, 16'h001e, "config write");
        check({14'h0000, ptr}, 16'h0001, "pointer kept");
        $display("write test done");
    endtask
    task automatic t_loop();
        logic [15:0] exp [4];
        exp = '{temp, 16'h001e, 16'h2d00, 16'hc680};
        for (int p = 0; p < 4; p++) begin
            rd(1'b1, p[1:0], (p == 1) ? 1 : 2);
            check(w, exp[p], "pointer set then read");
            check({14'h0000, ptr}, p[15:0], "pointer load");
        end
        $display("pointer loop test done");
    endtask
    task automatic t_preset();
        rd(1'b0, 2'h0, 2);
        check(w, 16'hc680, "preset pointer read");
        rd(1'b1, tsr_pkg::PTR_CONF, 1);
        check(w, 16'h001e, "config set then read");
        temp = 16'h0000;
        rd(1'b0, 2'h0, 1);
        check(w, 16'h001e, "preset config read");
        $display("preset test done");
    endtask
    task automatic t_wrong();
        logic [7:0] b;
        logic a;
        M.start();
        M.xfer({tsr_pkg::ADDR_FIXED, pins ^ 3'h1, 1'b0}, 1'b1, b, a);
        check({15'h0000, a}, 16'h0001, "foreign address acked");
        M.xfer(8'h02, 1'b1, b, a);
        M.stop();
        check({14'h0000, ptr}, 16'h0001, "pointer disturbed");
        pins = 3'h2;
        rd(1'b1, tsr_pkg::PTR_LOWER, 2);
        check(w, 16'h2d00, "new select pins");
        $display("address test done");
    endtask
    // Device holds the data line low on a read, master stops clocking
    task automatic t_timeout();
        int pulses;
        pulses = 0;
        M.start();
        send({tsr_pkg::ADDR_FIXED, pins, 1'b1});
        repeat (4) @(negedge clock_i);
        check({15'h0000, sda}, 16'h0000, "data not driven");
        repeat (TO_CYC + 20) begin
            @(negedge clock_i);
            pulses += tmo;
        end
        check(pulses[15:0], 16'h0001, "time-out pulses");
        check({15'h0000, sda}, 16'h0001, "data line held");
        M.stop();
        rd(1'b0, 2'h0, 2);
        check(w, 16'h2d00, "read after time-out");
        $display("time-out test done");
    endtask
    initial begin
        repeat (8) @(negedge clock_i);
        nrst_i = 1'b1;
        repeat (2) @(negedge clock_i);
        t_reset();
        t_default();
        t_writes();
        t_loop();
        t_preset();
        t_wrong();
        t_timeout();
        nrst_i = 1'b0;
        repeat (2) @(negedge clock_i);
        nrst_i = 1'b1;
        repeat (2) @(negedge clock_i);
        t_reset();
        close_out();
    end
endmodule

// file: verilog/tsr_line_watch.sv
/*
 * Edge and condition detector for the two-wire bus lines, plus the
 * data-low time-out counter.
 * Assumes scl and sda are already synchronous to clock_i.
 */
`timescale 1ns/1ns
module tsr_line_watch #(
    parameter longint TIMEOUT_CYC = tsr_pkg::TIMEOUT_CYC
) (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_rise_o,
    output logic scl_fall_o,
    output logic start_o,
    output logic stop_o,
    output logic timeout_o
);
    logic scl_q, sda_q, next_scl_q, next_sda_q;
    logic [31:0] low_cnt, next_low_cnt;
    logic next_timeout;

    always_comb begin
        next_scl_q = scl_i;
        next_sda_q = sda_i;
        next_low_cnt = 32'h0;
        next_timeout = 1'b0;
        if (!sda_i) begin
            if (low_cnt >= 32'(TIMEOUT_CYC - 1)) begin
                next_timeout = (low_cnt == 32'(TIMEOUT_CYC - 1));
                next_low_cnt = low_cnt;
                if (next_timeout)
                    next_low_cnt = low_cnt + 32'h1;
            end else begin
                next_low_cnt = low_cnt + 32'h1;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            low_cnt <= 32'h0;
            timeout_o <= 1'b0;
        end else begin
            scl_q <= next_scl_q;
            sda_q <= next_sda_q;
            low_cnt <= next_low_cnt;
            timeout_o <= next_timeout;
        end
    end

    assign scl_rise_o = scl_i & ~scl_q;
    assign scl_fall_o = ~scl_i & scl_q;
    assign start_o = scl_i & scl_q & sda_q & ~sda_i;
    assign stop_o = scl_i & scl_q & ~sda_q & sda_i;
endmodule

// file: verilog/tsr_slave.sv
/*
 * Two-wire slave front end of a temperature sensor: address match,
 * pointer load, register reads and writes, bus time-out.
 * Assumes synchronous scl/sda inputs and an external open-drain pad
 * driven low while sda_oe_o is high.
 */
// Summary of operation
// - Address with write bit, acknowledged, then next byte loads pointer.
// - Reads use the preset pointer or one just loaded.
// - Pointer selects temperature by default.
// - Write: first byte after address is stored as pointer.
// - Temperature and limit reads return two bytes, high first.
// - Configuration read returns one byte.
// - Pointer load then repeated start read returns the new register.
// - Configuration pointer load then one-byte read in one sequence.
// - Data line low past time-out resets interface, releases line.
// - Pointer is zero after reset.
// - Each byte is eight bits plus one acknowledge bit.
`timescale 1ns/1ns
module tsr_slave #(
    parameter longint TIMEOUT_CYC = tsr_pkg::TIMEOUT_CYC
) (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic [2:0] address_select_pins_i,
    input wire logic [15:0] temp_i,
    output logic sda_o,
    output logic sda_oe_o,
    output logic [1:0] pointer_word_address_o,
    output logic [7:0] conf_o,
    output logic [15:0] upper_trip_limit_o,
    output logic [15:0] lower_trip_limit_o,
    output logic timeout_o
);
    // ****************************************
    // Line events
    // ****************************************
    logic scl_rise, scl_fall, start_c, stop_c, tmo;

    tsr_line_watch #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_watch (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .scl_rise_o(scl_rise),
        .scl_fall_o(scl_fall),
        .start_o(start_c),
        .stop_o(stop_c),
        .timeout_o(tmo)
    );

    // ****************************************
    // State
    // ****************************************
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_ACK, ST_RX, ST_TX, ST_MACK
    } tsr_state_t;

    tsr_state_t state, next_state;
    logic [7:0] shreg, next_shreg;
    logic [3:0] bitcnt, next_bitcnt;
    logic [1:0] bytecnt, next_bytecnt;
    logic rd, next_rd;
    logic [1:0] ptr, next_ptr;
    logic [7:0] conf, next_conf;
    logic [15:0] upper, next_upper, lower, next_lower;
    logic [7:0] hi_hold, next_hi_hold;
    logic sda_oe, next_sda_oe;
    logic [15:0] sel_word;

    // Register selection from pointer
    always_comb begin
        case (ptr)
            tsr_pkg::PTR_TEMP: sel_word = temp_i;
            tsr_pkg::PTR_CONF: sel_word = {conf, 8'h00};
            tsr_pkg::PTR_LOWER: sel_word = lower;
            tsr_pkg::PTR_UPPER: sel_word = upper;
            default: sel_word = temp_i;
        endcase
    end

    always_comb begin
        next_state = state;
        next_shreg = shreg;
        next_bitcnt = bitcnt;
        next_bytecnt = bytecnt;
        next_rd = rd;
        next_ptr = ptr;
        next_conf = conf;
        next_upper = upper;
        next_lower = lower;
        next_hi_hold = hi_hold;
        next_sda_oe = sda_oe;
        if (tmo) begin
            // Release the line and drop the transfer
            next_state = ST_IDLE;
            next_sda_oe = 1'b0;
        end else if (start_c) begin
            next_state = ST_ADDR;
            next_bitcnt = 4'h0;
            next_sda_oe = 1'b0;
        end else if (stop_c) begin
            next_state = ST_IDLE;
            next_sda_oe = 1'b0;
        end else begin
            case (state)
                ST_ADDR: begin
                    if (scl_rise) begin
                        next_shreg = {shreg[6:0], sda_i};
                        next_bitcnt = bitcnt + 4'h1;
                    end
                    if (scl_fall && bitcnt == 4'h8) begin
                        if (shreg[7:1] ==
                            {tsr_pkg::ADDR_FIXED, address_select_pins_i}) begin
                            next_rd = shreg[0];
                            next_sda_oe = 1'b1;
                            next_bytecnt = 2'h0;
                            next_state = ST_ACK;
                        end else begin
                            next_state = ST_IDLE;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        next_bitcnt = 4'h0;
                        if (rd) begin
                            next_hi_hold = sel_word[7:0];
                            next_shreg = sel_word[15:8];
                            next_sda_oe = ~sel_word[15];
                            next_state = ST_TX;
                        end else begin
                            next_sda_oe = 1'b0;
                            next_state = ST_RX;
                        end
                    end
                end
                ST_RX: begin
                    if (scl_rise) begin
                        next_shreg = {shreg[6:0], sda_i};
                        next_bitcnt = bitcnt + 4'h1;
                    end
                    if (scl_fall && bitcnt == 4'h8) begin
                        next_sda_oe = 1'b1;
                        next_state = ST_ACK;
                        if (bytecnt != 2'h3)
                            next_bytecnt = bytecnt + 2'h1;
                        case (bytecnt)
                            2'h0: next_ptr = shreg[1:0];
                            2'h1: begin
                                if (ptr == tsr_pkg::PTR_CONF)
                                    next_conf = shreg;
                                else if (ptr == tsr_pkg::PTR_UPPER)
                                    next_upper[15:8] = shreg;
                                else if (ptr == tsr_pkg::PTR_LOWER)
                                    next_lower[15:8] = shreg;
                            end
                            2'h2: begin
                                if (ptr == tsr_pkg::PTR_UPPER)
                                    next_upper[7:0] = shreg;
                                else if (ptr == tsr_pkg::PTR_LOWER)
                                    next_lower[7:0] = shreg;
                            end
                            default: ;
                        endcase
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        next_bitcnt = bitcnt + 4'h1;
                        next_shreg = {shreg[6:0], 1'b0};
                        if (bitcnt == 4'h7) begin
                            next_sda_oe = 1'b0;
                            next_state = ST_MACK;
                        end else begin
                            next_sda_oe = ~shreg[6];
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        next_shreg[0] = sda_i;
                    end
                    if (scl_fall) begin
                        next_bitcnt = 4'h0;
                        // Master nack ends the read; the line stays released
                        if (shreg[0]) begin
                            next_state = ST_IDLE;
                        end else if (bytecnt == 2'h0 &&
                                     ptr != tsr_pkg::PTR_CONF) begin
                            next_bytecnt = 2'h1;
                            next_shreg = hi_hold;
                            next_sda_oe = ~hi_hold[7];
                            next_state = ST_TX;
                        end else begin
                            // Further bytes repeat the selected word
                            next_bytecnt = 2'h0;
                            next_hi_hold = sel_word[7:0];
                            next_shreg = sel_word[15:8];
                            next_sda_oe = ~sel_word[15];
                            next_state = ST_TX;
                        end
                    end
                end
                default: next_state = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            state <= ST_IDLE;
            shreg <= 8'h00;
            bitcnt <= 4'h0;
            bytecnt <= 2'h0;
            rd <= 1'b0;
            ptr <= tsr_pkg::PTR_RESET;
            conf <= tsr_pkg::CONF_RESET;
            upper <= tsr_pkg::UPPER_RESET;
            lower <= tsr_pkg::LOWER_RESET;
            hi_hold <= 8'h00;
            sda_oe <= 1'b0;
        end else begin
            state <= next_state;
            shreg <= next_shreg;
            bitcnt <= next_bitcnt;
            bytecnt <= next_bytecnt;
            rd <= next_rd;
            ptr <= next_ptr;
            conf <= next_conf;
            upper <= next_upper;
            lower <= next_lower;
            hi_hold <= next_hi_hold;
            sda_oe <= next_sda_oe;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            sda_o <= 1'b0;
            sda_oe_o <= 1'b0;
            pointer_word_address_o <= tsr_pkg::PTR_RESET;
            conf_o <= tsr_pkg::CONF_RESET;
            upper_trip_limit_o <= tsr_pkg::UPPER_RESET;
            lower_trip_limit_o <= tsr_pkg::LOWER_RESET;
            timeout_o <= 1'b0;
        end else begin
            sda_o <= 1'b0;
            sda_oe_o <= next_sda_oe;
            pointer_word_address_o <= next_ptr;
            conf_o <= next_conf;
            upper_trip_limit_o <= next_upper;
            lower_trip_limit_o <= next_lower;
            timeout_o <= tmo;
        end
    end
endmodule
